/* a32wd_params.svh */
// constants for the extender wide address window decoder
`ifndef A32WD_PARAMS_SVH
`define A32WD_PARAMS_SVH

// ==================================================
// register map
`define A32WD_CFG_ADDR_W     6
`define A32WD_WINDOW_OFS     6'h10
`define A32WD_RESET_VALUE    16'h0000

// ==================================================
// field positions
`define A32WD_BIT_RSVD_ZERO  15
`define A32WD_BIT_ENABLE     14
`define A32WD_BIT_DIRECTION  13
`define A32WD_BIT_ONES_HI    12
`define A32WD_BIT_ONES_LO    11
`define A32WD_SIZE_HI        10
`define A32WD_SIZE_LO        8
`define A32WD_BASE_HI        7
`define A32WD_BASE_LO        0
`define A32WD_ONES_VALUE     2'h3

// ==================================================
// decode geometry
`define A32WD_ADDR_TOP       31
`define A32WD_ADDR_LOW       24
`define A32WD_SPAN_SHIFT     32

`endif

/* a32wd_pkg.sv */
// types shared by the extender wide address window decoder
package a32wd_pkg;
    typedef logic [2:0]  a32wd_size_t;
    typedef logic [7:0]  a32wd_base_t;
    typedef logic [15:0] a32wd_word_t;
    typedef logic [32:0] a32wd_span_t;
endpackage

/* a32wd_match.sv */
// window match: compares the top size bits of address 31..24 with the base
`timescale 1ns/1ps
module a32wd_match (
    // window setting
    input  wire a32wd_pkg::a32wd_size_t windowSize,
    input  wire a32wd_pkg::a32wd_base_t windowBase,
    // address lines 31..24 of the cycle
    input  wire a32wd_pkg::a32wd_base_t addrHigh,
    // result
    output logic                        windowHit
);
    import a32wd_pkg::*;

    logic [7:0] bitOk;

    // bit i is compared only when it lies among the top windowSize bits
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_cmp
            assign bitOk[i] = ({1'b0, windowSize} <= (4'(7) - 4'(i))) ||
                              (addrHigh[i] == windowBase[i]);
        end
    endgenerate

    // size zero leaves every bit ignored, so every address matches
    assign windowHit = &bitOk;
endmodule

/* a32wd_window_decode.sv */
// extender wide address window register and forwarding decision
//
// Summary of operation
// - writing one to the enable bit turns on forwarding through the window
// - with enable clear no wide address cycle crosses in either direction
// - direction set: range picks cable cycles forwarded inward to backplane
// - direction clear: range picks backplane cycles forwarded out to cable
// - addresses outside the range cross the opposite way, one way only
// - size field says how many top base bits are compared; rest ignored
// - window covers 16777216 times two to the eight minus size addresses
// - base in bits 7..0 is compared with address lines 31..24
// - hard reset clears all fields; soft reset leaves them untouched
// - bit 15 reads zero; writes to it have no effect
// - bits 12 and 11 read as ones; writes to them have no effect
// - new setting takes effect only once the lower byte is written
// - own address decoder wins over the window on both buses
// - compatibility layout bit set turns off all forwarding through the window
// - sixteen bit location at offset 10 hex, byte accesses allowed
`timescale 1ns/1ps
`include "a32wd_params.svh"
module a32wd_window_decode (
    // clock and hard reset
    input  wire logic                          sys_clk,
    input  wire logic                          sys_rst,
    // soft reset, leaves the window setting alone
    input  wire logic                          softRst,
    // compatibility layout bit from the bridge control register
    input  wire logic                          compatLayoutMode,
    // configuration space access
    input  wire logic                          cfgSel,
    input  wire logic                          cfgWrite,
    input  wire logic [`A32WD_CFG_ADDR_W-1:0]  cfgAddr,
    input  wire logic [1:0]                    cfgByteEn,
    input  wire a32wd_pkg::a32wd_word_t        cfgWrData,
    output a32wd_pkg::a32wd_word_t             cfgRdData,
    output logic                               cfgAck,
    // backplane cycle
    input  wire logic                          bpCycleValid,
    input  wire logic                          bpOwnHit,
    input  wire logic [31:0]                   bpAddr,
    // cable cycle
    input  wire logic                          cbCycleValid,
    input  wire logic                          cbOwnHit,
    input  wire logic [31:0]                   cbAddr,
    // decisions
    output logic                               bpForwardOut,
    output logic                               bpClaimOwn,
    output logic                               cbForwardIn,
    output logic                               cbClaimOwn,
    output a32wd_pkg::a32wd_span_t             windowSpan
);
    import a32wd_pkg::*;

    // ==================================================
    // window register
    logic          stgEnable_q;
    logic          stgDirection_q;
    a32wd_size_t   stgSize_q;
    a32wd_base_t   windowBase_q;
    logic          windowEnable_q;
    logic          windowDirection_q;
    a32wd_size_t   windowSize_q;
    a32wd_word_t   cfgRdData_q;
    logic          cfgAck_q;
    logic          regHit;
    logic          wrHi;
    logic          wrLo;
    a32wd_word_t   readWord;

    assign regHit = cfgSel && (cfgAddr == `A32WD_WINDOW_OFS);
    assign wrHi   = regHit && cfgWrite && cfgByteEn[1];
    assign wrLo   = regHit && cfgWrite && cfgByteEn[0];

    // upper byte lands in a staging copy; bits 15, 12, 11 are dropped
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stgEnable_q    <= 1'b0;
            stgDirection_q <= 1'b0;
            stgSize_q      <= 3'h0;
        end else if (wrHi) begin
            stgEnable_q    <= cfgWrData[`A32WD_BIT_ENABLE];
            stgDirection_q <= cfgWrData[`A32WD_BIT_DIRECTION];
            stgSize_q      <= cfgWrData[`A32WD_SIZE_HI:`A32WD_SIZE_LO];
        end
    end

    // lower byte write stores the base and commits the staged upper byte
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            windowBase_q      <= 8'h00;
            windowEnable_q    <= 1'b0;
            windowDirection_q <= 1'b0;
            windowSize_q      <= 3'h0;
        end else if (wrLo) begin
            windowBase_q      <= cfgWrData[`A32WD_BASE_HI:`A32WD_BASE_LO];
            windowEnable_q    <= wrHi ? cfgWrData[`A32WD_BIT_ENABLE] : stgEnable_q;
            windowDirection_q <= wrHi ? cfgWrData[`A32WD_BIT_DIRECTION] : stgDirection_q;
            windowSize_q      <= wrHi ? cfgWrData[`A32WD_SIZE_HI:`A32WD_SIZE_LO] : stgSize_q;
        end
    end

    // read word shows the last written values with the fixed reserved bits
    always_comb begin
        readWord = `A32WD_RESET_VALUE;
        readWord[`A32WD_BIT_RSVD_ZERO] = 1'b0;
        readWord[`A32WD_BIT_ENABLE] = stgEnable_q;
        readWord[`A32WD_BIT_DIRECTION] = stgDirection_q;
        readWord[`A32WD_BIT_ONES_HI:`A32WD_BIT_ONES_LO] = `A32WD_ONES_VALUE;
        readWord[`A32WD_SIZE_HI:`A32WD_SIZE_LO] = stgSize_q;
        readWord[`A32WD_BASE_HI:`A32WD_BASE_LO] = windowBase_q;
    end

    // registered read data and one-cycle acknowledge; unselected lanes read zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cfgRdData_q <= 16'h0000;
            cfgAck_q    <= 1'b0;
        end else begin
            cfgAck_q    <= regHit;
            cfgRdData_q <= (regHit && !cfgWrite) ?
                           (readWord & {{8{cfgByteEn[1]}}, {8{cfgByteEn[0]}}}) : 16'h0000;
        end
    end

    assign cfgRdData = cfgRdData_q;
    assign cfgAck    = cfgAck_q;

    // ==================================================
    // pin synchronisers: three stages, a change counts once stages two and three agree
    localparam int SW = 34;
    logic [SW-1:0] bpS1_q, bpS2_q, bpS3_q;
    logic [SW-1:0] cbS1_q, cbS2_q, cbS3_q;
    logic          bpStable;
    logic          cbStable;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bpS1_q <= '0;
            bpS2_q <= '0;
            bpS3_q <= '0;
            cbS1_q <= '0;
            cbS2_q <= '0;
            cbS3_q <= '0;
        end else begin
            bpS1_q <= {bpCycleValid, bpOwnHit, bpAddr};
            bpS2_q <= bpS1_q;
            bpS3_q <= bpS2_q;
            cbS1_q <= {cbCycleValid, cbOwnHit, cbAddr};
            cbS2_q <= cbS1_q;
            cbS3_q <= cbS2_q;
        end
    end

    assign bpStable = (bpS2_q == bpS3_q);
    assign cbStable = (cbS2_q == cbS3_q);

    // ==================================================
    // window match for each bus
    logic bpInRange;
    logic cbInRange;
    logic winLive;

    a32wd_match u_bp_match (
        .windowSize (windowSize_q),
        .windowBase (windowBase_q),
        .addrHigh   (bpS3_q[`A32WD_ADDR_TOP:`A32WD_ADDR_LOW]),
        .windowHit  (bpInRange)
    );

    a32wd_match u_cb_match (
        .windowSize (windowSize_q),
        .windowBase (windowBase_q),
        .addrHigh   (cbS3_q[`A32WD_ADDR_TOP:`A32WD_ADDR_LOW]),
        .windowHit  (cbInRange)
    );

    // this layout is only live with compatibility layout clear
    assign winLive = windowEnable_q && !compatLayoutMode;

    // ==================================================
    // forwarding decisions, updated when the synchronised inputs have settled
    logic bpForwardOut_q, bpClaimOwn_q, cbForwardIn_q, cbClaimOwn_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bpForwardOut_q <= 1'b0;
            bpClaimOwn_q   <= 1'b0;
        end else if (bpStable) begin
            bpClaimOwn_q   <= bpS3_q[33] && bpS3_q[32];
            bpForwardOut_q <= bpS3_q[33] && !bpS3_q[32] && winLive &&
                              (windowDirection_q ? !bpInRange : bpInRange);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cbForwardIn_q <= 1'b0;
            cbClaimOwn_q  <= 1'b0;
        end else if (cbStable) begin
            cbClaimOwn_q  <= cbS3_q[33] && cbS3_q[32];
            cbForwardIn_q <= cbS3_q[33] && !cbS3_q[32] && winLive &&
                             (windowDirection_q ? cbInRange : !cbInRange);
        end
    end

    assign bpForwardOut = bpForwardOut_q;
    assign bpClaimOwn   = bpClaimOwn_q;
    assign cbForwardIn  = cbForwardIn_q;
    assign cbClaimOwn   = cbClaimOwn_q;

    // ==================================================
    // span of the active window in addresses
    a32wd_span_t windowSpan_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            windowSpan_q <= 33'h100000000;
        end else begin
            windowSpan_q <= 33'h1 << (6'(`A32WD_SPAN_SHIFT) - {3'h0, windowSize_q});
        end
    end

    assign windowSpan = windowSpan_q;

    // soft reset deliberately touches nothing here
    logic softRstSeen;
    assign softRstSeen = softRst;
endmodule

/* a32wd_far_master.sv */
// far side master model driving one bus's wide address cycle pins
`timescale 1ns/1ps
module a32wd_far_master (
    // clock
    input  wire logic        sys_clk,
    // cycle request from the bench
    input  wire logic        reqValid,
    input  wire logic        reqOwn,
    input  wire logic [31:0] reqAddr,
    // bus pins
    output logic             cycValid,
    output logic             cycOwn,
    output logic [31:0]      cycAddr
);
    initial begin
        cycValid = 1'b0;
        cycOwn = 1'b0;
        cycAddr = 32'h0;
    end
    // pins move just after the edge; a released address shows its inverse
    always @(posedge sys_clk) begin
        cycValid <= reqValid;
        cycOwn <= reqValid & reqOwn;
        if (reqValid)
            cycAddr <= reqAddr;
        else if (cycValid)
            cycAddr <= ~cycAddr;
    end
endmodule

/* a32wd_window_checker.sv */
// port assertions and bind for the wide address window decoder
`timescale 1ns/1ps
`include "a32wd_params.svh"
module a32wd_window_checker (
    // clock and hard reset
    input wire logic            sys_clk,
    input wire logic            sys_rst,
    // layout bit and configuration access
    input wire logic            compatLayoutMode,
    input wire logic            cfgSel,
    input wire logic            cfgWrite,
    input wire logic [5:0]      cfgAddr,
    input wire logic [1:0]      cfgByteEn,
    input wire a32wd_pkg::a32wd_word_t cfgRdData,
    input wire logic            cfgAck,
    // cycles and decisions
    input wire logic            bpCycleValid,
    input wire logic [31:0]     bpAddr,
    input wire logic            cbCycleValid,
    input wire logic [31:0]     cbAddr,
    input wire logic            bpForwardOut,
    input wire logic            bpClaimOwn,
    input wire logic            cbForwardIn,
    input wire logic            cbClaimOwn,
    input wire a32wd_pkg::a32wd_span_t windowSpan
);
    import a32wd_pkg::*;
    default clocking cbk @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    AST_ACK_AFTER_SEL: assert property (cfgSel && cfgAddr == `A32WD_WINDOW_OFS |=> cfgAck)
        else $error("ack missing");
    AST_NO_ACK_ELSE: assert property (!(cfgSel && cfgAddr == `A32WD_WINDOW_OFS) |=> !cfgAck)
        else $error("stray ack");
    AST_FIXED_BITS: assert property (cfgAck && !$past(cfgWrite) && $past(cfgByteEn[1])
        |-> !cfgRdData[15] && cfgRdData[12:11] == 2'h3)
        else $error("fixed bits wrong");
    AST_RESET_CLEAR: assert property (disable iff (1'b0) sys_rst |=> windowSpan == 33'h100000000 && !bpForwardOut && !cbForwardIn && !cfgAck)
        else $error("reset state wrong");
    AST_SPAN_POW2: assert property ($onehot(windowSpan) && windowSpan >= 33'h001000000)
        else $error("span not a legal size");
    AST_OWN_FIRST: assert property (!(bpClaimOwn && bpForwardOut) && !(cbClaimOwn && cbForwardIn))
        else $error("own space forwarded");
    AST_COMPAT_HOLD: assert property (compatLayoutMode [*5] |-> !bpForwardOut && !cbForwardIn)
        else $error("forwarding in other layout");
    AST_ONE_WAY: assert property ((bpAddr == cbAddr && bpCycleValid && cbCycleValid && $stable(bpAddr)) [*5]
        |-> !(bpForwardOut && cbForwardIn))
        else $error("address crosses both ways");
    COV_OUT: cover property (bpForwardOut);
    COV_IN: cover property (cbForwardIn);
    COV_OWN: cover property (bpClaimOwn && cbClaimOwn);
endmodule
bind a32wd_window_decode a32wd_window_checker u_a32wd_window_checker (.sys_clk, .sys_rst, .compatLayoutMode,
    .cfgSel, .cfgWrite, .cfgAddr, .cfgByteEn, .cfgRdData, .cfgAck, .bpCycleValid, .bpAddr, .cbCycleValid,
    .cbAddr, .bpForwardOut, .bpClaimOwn, .cbForwardIn, .cbClaimOwn, .windowSpan);

/* a32wd_window_decode_tb.sv */
// self-checking bench for the wide address window decoder
`timescale 1ns/1ps
module a32wd_window_decode_tb;
    import a32wd_pkg::*;
    // ==================================================
    // pins and bench model
    logic sys_clk = 1'b0, sys_rst = 1'b1, softRst = 1'b0, compat = 1'b0, cfgSel = 1'b0, cfgWrite = 1'b0;
    logic cfgAck, decChk = 1'b0, bv = 1'b0, bo = 1'b0, cv = 1'b0, co = 1'b0, bpV, bpO, cbV, cbO;
    logic bpF, bpC, cbF, cbC, stgEn = 1'b0, stgDir = 1'b0, cEn = 1'b0, cDir = 1'b0;
    logic [5:0] cfgAddr = 6'h0;
    logic [1:0] cfgByteEn = 2'h0;
    logic [31:0] addr = 32'h0, bpA, cbA, r;
    logic [16:0] e, rdQ[$];
    logic [36:0] decQ[$];
    a32wd_word_t cfgWrData = 16'h0, cfgRdData;
    a32wd_span_t span;
    a32wd_size_t stgSize = 3'h0, cSize = 3'h0;
    a32wd_base_t base = 8'h0, hiMask;
    integer seed, bad_count = 0, n_tests = 0, cycles = 0, i;
    a32wd_window_decode u_a32wd_window_decode (.sys_clk, .sys_rst, .softRst, .compatLayoutMode(compat), .cfgSel,
        .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWrData, .cfgRdData, .cfgAck, .bpCycleValid(bpV), .bpOwnHit(bpO),
        .bpAddr(bpA), .cbCycleValid(cbV), .cbOwnHit(cbO), .cbAddr(cbA), .bpForwardOut(bpF), .bpClaimOwn(bpC),
        .cbForwardIn(cbF), .cbClaimOwn(cbC), .windowSpan(span));
    a32wd_far_master u_a32wd_far_master (.sys_clk, .reqValid(bv), .reqOwn(bo), .reqAddr(addr), .cycValid(bpV),
        .cycOwn(bpO), .cycAddr(bpA));
    a32wd_far_master u_a32wd_far_master_cb (.sys_clk, .reqValid(cv), .reqOwn(co), .reqAddr(addr), .cycValid(cbV),
        .cycOwn(cbO), .cycAddr(cbA));
    always #50 sys_clk = ~sys_clk;
    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            summarize();
        end
    end
    // ==================================================
    // drivers, model and checks
    task automatic access(input logic wr, input logic [5:0] ofs, input logic [1:0] be, input a32wd_word_t d);
        {cfgSel, cfgWrite, cfgAddr, cfgByteEn, cfgWrData} = {1'b1, wr, ofs, be, d};
        @(negedge sys_clk);
        cfgSel = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic wrReg(input logic [1:0] be, input a32wd_word_t d);
        if (be[1]) {stgEn, stgDir, stgSize} = {d[14:13], d[10:8]};
        if (be[0]) {cEn, cDir, cSize, base} = {stgEn, stgDir, stgSize, d[7:0]};
        rdQ.push_back(17'h0);
        access(1'b1, 6'h10, be, d);
    endtask
    task automatic rdReg(input logic [1:0] be);
        rdQ.push_back({1'b1, be[1] ? {1'b0, stgEn, stgDir, 2'h3, stgSize} : 8'h0, be[0] ? base : 8'h0});
        access(1'b0, 6'h10, be, 16'h0);
    endtask
    function automatic logic [3:0] expDec(input logic hit);
        expDec = {bv & ~bo & cEn & ~compat & (cDir ^ hit), bv & bo, cv & ~co & cEn & ~compat & ~(cDir ^ hit), cv & co};
    endfunction
    task automatic checkWord(input a32wd_word_t exp);
        n_tests++;
        if (cfgRdData !== exp) begin
            bad_count++;
            $display("BAD cfgRdData exp %h got %h", exp, cfgRdData);
        end
    endtask
    task automatic checkDec(input logic [36:0] exp);
        n_tests++;
        if ({span, bpF, bpC, cbF, cbC} !== exp) begin
            bad_count++;
            $display("BAD decisions exp %h got %h", exp, {span, bpF, bpC, cbF, cbC});
        end
    endtask
    task automatic summarize();
        if (rdQ.size() != 0 || decQ.size() != 0) begin
            bad_count++;
            $display("BAD pending exp 0 got %0d", rdQ.size() + decQ.size());
        end
        if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // output watcher, settled just after the falling edge
    always begin
        @(negedge sys_clk);
        #1;
        if (cfgAck !== 1'b0) begin
            e = (rdQ.size() != 0) ? rdQ.pop_front() : 17'h1xxxx;
            if (e[16]) checkWord(e[15:0]);
        end
        if (decChk) checkDec(decQ.pop_front());
    end
    // ==================================================
    // main sequence
    initial begin
        seed = 70114;
        repeat (8) @(negedge sys_clk);
        sys_rst = 1'b0;
        softRst = 1'b1;
        rdReg(2'h3);
        access(1'b0, 6'h12, 2'h3, 16'h0);
        wrReg(2'h3, 16'hffff);
        rdReg(2'h3);
        for (i = 0; i < 80; i++) begin
            // hard reset in mid-run clears a programmed window
            if (i == 40) begin
                sys_rst = 1'b1;
                {stgEn, stgDir, stgSize, cEn, cDir, cSize, base} = 18'h0;
                repeat (2) @(negedge sys_clk);
                sys_rst = 1'b0;
                rdReg(2'h3);
            end
            r = $random(seed);
            softRst = r[0];
            compat = (r[3:1] == 3'h0);
            wrReg(2'h2, r[31:16]);
            if (r[4]) wrReg(2'h1, r[15:0]);
            rdReg(r[6:5]);
            hiMask = a32wd_base_t'(16'h00ff << (4'd8 - cSize));
            addr = $random(seed);
            if (r[7]) addr[31:24] = base ^ (addr[31:24] & ~hiMask);
            {bv, bo, cv, co} = {r[8] | r[9], r[10] & r[11], r[12] | r[9], r[13] & r[14]};
            repeat (8) @(negedge sys_clk);
            decQ.push_back({33'h1 << (32 - cSize), expDec(((addr[31:24] ^ base) & hiMask) == 8'h0)});
            decChk = 1'b1;
            @(negedge sys_clk);
            decChk = 1'b0;
        end
        summarize();
    end
endmodule
